// >>> lbc_consts.svh
`ifndef LBC_CONSTS_SVH
`define LBC_CONSTS_SVH

// Clock and PWM timing
`define LBC_CLK_HZ 10000000
`define LBC_PWM_HZ 2000
`define LBC_PWM_CYCLES (`LBC_CLK_HZ / `LBC_PWM_HZ)
`define LBC_PCT_FULL 7'h64
`define LBC_PULSE_PERIODS 4'h8

// Channel counts
`define LBC_NUM_LED 11
`define LBC_NUM_GPIO 8
`define LBC_HI_BITS 3

// Register offsets
`define LBC_CFG2_ADDR 8'h40
`define LBC_DONE_LO_ADDR 8'h60
`define LBC_DONE_HI_ADDR 8'h61
`define LBC_DIR_ADDR 8'h70
`define LBC_TYPE_ADDR 8'h71
`define LBC_GPIN_ADDR 8'h72
`define LBC_OUT_LO_ADDR 8'h74
`define LBC_OUT_HI_ADDR 8'h75
`define LBC_TRANS_LO_ADDR 8'h77
`define LBC_TRANS_HI_ADDR 8'h78
`define LBC_MIRR_LO_ADDR 8'h79
`define LBC_MIRR_HI_ADDR 8'h7a
`define LBC_LINK_LO_ADDR 8'h7b
`define LBC_LINK_HI_ADDR 8'h7c
`define LBC_BEH_0_ADDR 8'h81
`define LBC_BEH_1_ADDR 8'h82
`define LBC_BEH_2_ADDR 8'h83
`define LBC_P1_DUTY_ADDR 8'h90
`define LBC_P2_DUTY_ADDR 8'h91
`define LBC_BR_DUTY_ADDR 8'h92
`define LBC_DIR_DUTY_ADDR 8'h93

// Reset values
`define LBC_ZERO_RST 8'h00
`define LBC_DUTY_RST 8'hf0

// Configuration 2 field positions
`define LBC_CFG2_DONE_INT 0
`define LBC_CFG2_P1_RELEASE 1

`endif

// >>> lbc_pkg.sv
package lbc_pkg;

	// Behaviour selected per LED
	typedef enum logic [1:0] {
		LBC_DIRECT,
		LBC_PULSE1,
		LBC_PULSE2,
		LBC_BREATHE
	} lbc_mode_t;

	// Brightness in percent of the PWM period
	typedef logic [6:0] lbc_pct_t;

endpackage

// >>> lbc_chan_if.sv
`timescale 1ns/1ps
// Configuration and results of one LED channel
interface lbc_chan_if;
	logic active; // Touch or host level seen by the channel
	lbc_pkg::lbc_mode_t mode; // Behaviour
	lbc_pkg::lbc_pct_t maxPct; // Bright level after mirroring
	lbc_pkg::lbc_pct_t minPct; // Dim level after mirroring
	logic smooth; // Ramp instead of jump on linked changes
	logic pulseOnRelease; // First pulse starts on release
	logic pwmWrap; // One cycle at the end of each PWM period
	logic [15:0] pwmCnt; // Shared PWM phase
	logic drive; // PWM output of the channel
	logic done; // One cycle when the behaviour completes

	modport top (output active, mode, maxPct, minPct, smooth, pulseOnRelease, pwmWrap, pwmCnt,
		input drive, done);
	modport chan (input active, mode, maxPct, minPct, smooth, pulseOnRelease, pwmWrap, pwmCnt,
		output drive, done);
endinterface

// >>> lbc_duty_decode.sv
`timescale 1ns/1ps
`include "lbc_consts.svh"
// Four-bit duty code to percent, finer at the low end
module lbc_duty_decode (
	input wire logic [3:0] code,
	input wire logic mirror,
	output lbc_pkg::lbc_pct_t pct
);
	lbc_pkg::lbc_pct_t raw; // Decoded level before mirroring

	// Near-logarithmic curve; small codes step gently [R5]
	always_comb begin
		case (code)
			4'h0: raw = 7'h00;
			4'h1: raw = 7'h07;
			4'h2: raw = 7'h09;
			4'h3: raw = 7'h0b;
			4'h4: raw = 7'h0e;
			4'h5: raw = 7'h11;
			4'h6: raw = 7'h14;
			4'h7: raw = 7'h17;
			4'h8: raw = 7'h1a;
			4'h9: raw = 7'h1e;
			4'ha: raw = 7'h23;
			4'hb: raw = 7'h28;
			4'hc: raw = 7'h2e;
			4'hd: raw = 7'h35;
			4'he: raw = 7'h40;
			default: raw = `LBC_PCT_FULL;
		endcase
		// Mirror flips the scale so an inverted pin still looks right [R7]
		pct = mirror ? lbc_pkg::lbc_pct_t'(`LBC_PCT_FULL - raw) : raw;
	end
endmodule // lbc_duty_decode

// >>> lbc_led_channel.sv
`timescale 1ns/1ps
`include "lbc_consts.svh"
// Behaviour sequencer and PWM comparator of one LED
module lbc_led_channel #(
	parameter int CYC_PER_PCT = 50
) (
	input wire logic core_clk,
	input wire logic rst_n,
	lbc_chan_if.chan ch
);
	typedef enum logic [1:0] {LBC_IDLE, LBC_BUSY} lbc_state_t;

	lbc_state_t state, next_state; // Pulse 1 in progress or not
	lbc_pkg::lbc_pct_t level, next_level; // Current brightness
	logic prevActive, next_prevActive; // For edge detection
	logic [3:0] phaseCnt, next_phaseCnt; // PWM periods in the phase
	logic phaseUp, next_phaseUp; // Blink phase or breathe direction
	logic drive, next_drive;
	logic done, next_done;
	logic rise, fall, start;
	lbc_pkg::lbc_pct_t target;

	assign ch.drive = drive;
	assign ch.done = done;

	////////////////////////////////////////////////////////////////
	// Behaviour next state
	always_comb begin
		next_state = state;
		next_level = level;
		next_prevActive = ch.active;
		next_phaseCnt = phaseCnt;
		next_phaseUp = phaseUp;
		next_done = 1'b0;
		rise = ch.active & ~prevActive;
		fall = ~ch.active & prevActive;
		start = ch.pulseOnRelease ? fall : rise; // [R2]
		target = ch.active ? ch.maxPct : ch.minPct;
		case (ch.mode)
			lbc_pkg::LBC_DIRECT: begin
				// Host writes or touches act as the level [R3]
				if (!ch.smooth) begin
					next_level = target;
				end else if (ch.pwmWrap && level < target) begin
					// Ramp one percent per period so the LED does not bounce [R6]
					next_level = level + 7'h01;
				end else if (ch.pwmWrap && level > target) begin
					next_level = level - 7'h01;
				end
				next_done = fall; // [R4]
			end
			lbc_pkg::LBC_PULSE1: begin
				case (state)
					LBC_IDLE: begin
						next_level = ch.minPct;
						if (start) begin
							next_state = LBC_BUSY;
							next_level = ch.maxPct;
							next_phaseCnt = 4'h0;
						end
					end
					LBC_BUSY: begin
						if (ch.pwmWrap) begin
							next_phaseCnt = phaseCnt + 4'h1;
							if (phaseCnt == `LBC_PULSE_PERIODS - 4'h1) begin
								next_state = LBC_IDLE;
								next_level = ch.minPct;
								next_done = 1'b1; // [R4]
							end
						end
					end
					default: next_state = LBC_IDLE;
				endcase
			end
			lbc_pkg::LBC_PULSE2: begin
				// Blink while active; finish on release
				if (ch.active && ch.pwmWrap) begin
					next_phaseCnt = phaseCnt + 4'h1;
					if (phaseCnt == `LBC_PULSE_PERIODS - 4'h1) begin
						next_phaseCnt = 4'h0;
						next_phaseUp = ~phaseUp;
						next_level = phaseUp ? ch.minPct : ch.maxPct;
					end
				end else if (!ch.active) begin
					next_level = ch.minPct;
					next_phaseUp = 1'b0;
				end
				next_done = fall; // [R4]
			end
			default: begin
				// Breathe: triangle between dim and bright levels
				if (ch.active && ch.pwmWrap) begin
					if (phaseUp) begin
						if (level >= ch.maxPct) next_phaseUp = 1'b0;
						else next_level = level + 7'h01;
					end else begin
						if (level <= ch.minPct) next_phaseUp = 1'b1;
						else next_level = level - 7'h01;
					end
				end else if (!ch.active) begin
					next_level = ch.minPct;
					next_phaseUp = 1'b1;
				end
				next_done = fall; // [R4]
			end
		endcase
		// Fixed-rate compare; duty only moves the threshold [R1]
		next_drive = ({16'h0000, ch.pwmCnt} < ({25'h000_0000, level} * 32'(CYC_PER_PCT)));
	end

	// Behaviour registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= LBC_IDLE;
			level <= 7'h00;
			prevActive <= 1'b0;
			phaseCnt <= 4'h0;
			phaseUp <= 1'b0;
			drive <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			level <= next_level;
			prevActive <= next_prevActive;
			phaseCnt <= next_phaseCnt;
			phaseUp <= next_phaseUp;
			drive <= next_drive;
			done <= next_done;
		end
	end
endmodule // lbc_led_channel

// >>> lbc_led_ctrl.sv
`timescale 1ns/1ps
`include "lbc_consts.svh"
// Overview of operation
// (R1) PWM runs at fixed 2000 Hz always
// (R2) First pulse starts on press or release
// (R3) Unlinked host output write acts as touch
// (R4) Finished behaviours set sticky status, optional interrupt
// (R5) Duty codes decode on near-logarithmic curve, reset F0h
// (R6) Transition control smooths linked sensor changes
// (R7) Mirror control inverts duty mapping per LED
// (R8) Configuration 2 holds linking and interrupt controls; here it holds pulse-release and interrupt, linking has its own registers
// (R9) Open-drain sink default; eight usable as GPIO
module lbc_led_ctrl #(
	parameter int PWM_CYCLES = `LBC_PWM_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic [`LBC_NUM_LED-1:0] sensorTouched,
	input wire logic [`LBC_NUM_GPIO-1:0] lampIn,
	output logic [`LBC_NUM_LED-1:0] lampOut,
	output logic [`LBC_NUM_LED-1:0] lampOe,
	output logic ledDoneAlert
);
	// Whole clocks per percent; when the period is not a multiple of 100
	// the remainder is lost and full scale stays slightly below 100%
	localparam int CYC_PER_PCT = PWM_CYCLES / 100;
	// Short names for the channel counts
	localparam int NL = `LBC_NUM_LED;
	localparam int NG = `LBC_NUM_GPIO;

	////////////////////////////////////////////////////////////////
	// Registers
	// Per-LED control bits, bit i belongs to LED i
	logic [NL-1:0] doneStatus, next_doneStatus; // Finished flags
	logic [NL-1:0] transCtl, next_transCtl; // Smoothing enables
	logic [NL-1:0] mirrorCtl, next_mirrorCtl; // Duty mirror enables
	logic [NL-1:0] outCtl, next_outCtl; // Host touch emulation
	logic [NL-1:0] linkCtl, next_linkCtl; // Sensor linking
	logic [23:0] behav, next_behav; // Two mode bits per LED
	logic [7:0] cfg2, next_cfg2; // Configuration 2
	// Duty codes: bright level in the high nibble, dim level in the low
	logic [7:0] dutyP1, next_dutyP1;
	logic [7:0] dutyP2, next_dutyP2;
	logic [7:0] dutyBr, next_dutyBr;
	logic [7:0] dutyDir, next_dutyDir;
	// Pin configuration; only the first eight pins can be GPIO
	logic [NG-1:0] dirCtl, next_dirCtl; // 1 makes a GPIO an input
	logic [NG-1:0] typeCtl, next_typeCtl; // 1 makes a GPIO push-pull
	logic [NG-1:0] gpioIn, next_gpioIn; // Sampled pin levels
	// Next values of the registered outputs
	logic [7:0] next_regRdata;
	logic next_ledDoneAlert;
	logic [NL-1:0] next_lampOut, next_lampOe;
	// One counter serves every channel so all PWM edges line up
	logic [15:0] pwmCnt, next_pwmCnt; // Shared PWM phase
	logic pwmWrap;

	// Per-channel results
	logic [NL-1:0] chDrive, chDone;
	// Read path scratch: zero padding and read-to-clear masks
	logic [7:0] hiPad;
	logic [NL-1:0] clrDone;

	// Wrap marks the last clock of a period; behaviours step on it
	assign pwmWrap = (pwmCnt == 16'(PWM_CYCLES - 1));

	////////////////////////////////////////////////////////////////
	// PWM time base, one period every 500 us whatever the duties are
	// The period never depends on duty or behaviour settings, so
	// brightness changes cannot shift the flicker frequency
	always_comb begin
		next_pwmCnt = pwmWrap ? 16'h0000 : pwmCnt + 16'h0001; // [R1]
	end

	// Phase register, cleared by reset so channels start at a period edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwmCnt <= 16'h0000;
		end else begin
			pwmCnt <= next_pwmCnt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Channels
	// Behaviour selects which duty register a channel decodes
	genvar gi;
	generate
		for (gi = 0; gi < NL; gi++) begin : g_chan
			// Decoders are pure logic, so in direct mode a duty write
			// shows on the pin three clocks after it is taken
			lbc_chan_if chIf();
			logic [7:0] dutySel;
			lbc_pkg::lbc_mode_t modeSel;
			lbc_pkg::lbc_pct_t maxPct, minPct;

			assign modeSel = lbc_pkg::lbc_mode_t'(behav[2*gi +: 2]);
			// Each behaviour owns its duty register
			assign dutySel = (modeSel == lbc_pkg::LBC_PULSE1) ? dutyP1 :
				(modeSel == lbc_pkg::LBC_PULSE2) ? dutyP2 :
				(modeSel == lbc_pkg::LBC_BREATHE) ? dutyBr : dutyDir;

			lbc_duty_decode u_max (
				.code(dutySel[7:4]),
				.mirror(mirrorCtl[gi]),
				.pct(maxPct)
			); // [R5] [R7]
			// Dim level shares the mirror bit so both ends flip together
			lbc_duty_decode u_min (
				.code(dutySel[3:0]),
				.mirror(mirrorCtl[gi]),
				.pct(minPct)
			);

			// Linked LEDs follow the sensor, others follow host writes [R3]
			assign chIf.active = linkCtl[gi] ? sensorTouched[gi] : outCtl[gi];
			assign chIf.mode = modeSel;
			assign chIf.maxPct = maxPct;
			assign chIf.minPct = minPct;
			// Smoothing only matters when a sensor drives the LED [R6]
			assign chIf.smooth = transCtl[gi] & linkCtl[gi];
			assign chIf.pulseOnRelease = cfg2[`LBC_CFG2_P1_RELEASE]; // [R2] [R8]
			// Every channel sees the same phase and wrap
			assign chIf.pwmWrap = pwmWrap;
			assign chIf.pwmCnt = pwmCnt;
			assign chDrive[gi] = chIf.drive;
			assign chDone[gi] = chIf.done;

			// Sequencer and comparator for this LED
			lbc_led_channel #(
				.CYC_PER_PCT(CYC_PER_PCT)
			) u_chan (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.ch(chIf)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Register file, read data and status
	// Every control register holds its value unless the host addresses it
	always_comb begin
		next_transCtl = transCtl;
		next_mirrorCtl = mirrorCtl;
		next_outCtl = outCtl;
		next_linkCtl = linkCtl;
		next_behav = behav;
		next_cfg2 = cfg2;
		next_dutyP1 = dutyP1;
		next_dutyP2 = dutyP2;
		next_dutyBr = dutyBr;
		next_dutyDir = dutyDir;
		next_dirCtl = dirCtl;
		next_typeCtl = typeCtl;
		next_regRdata = regRdata;
		// Nothing is cleared unless a status register is read
		clrDone = '0;
		hiPad = 8'h00;
		// A read and a write in one cycle both take effect;
		// the read returns the value from before the write
		if (regWrite) begin
			case (regAddr)
				`LBC_CFG2_ADDR: next_cfg2 = regWdata; // [R8]
				`LBC_DIR_ADDR: next_dirCtl = regWdata;
				`LBC_TYPE_ADDR: next_typeCtl = regWdata;
				`LBC_OUT_LO_ADDR: next_outCtl[7:0] = regWdata; // [R3]
				`LBC_OUT_HI_ADDR: next_outCtl[NL-1:8] = regWdata[`LBC_HI_BITS-1:0];
				`LBC_TRANS_LO_ADDR: next_transCtl[7:0] = regWdata; // [R6]
				`LBC_TRANS_HI_ADDR: next_transCtl[NL-1:8] = regWdata[`LBC_HI_BITS-1:0];
				`LBC_MIRR_LO_ADDR: next_mirrorCtl[7:0] = regWdata; // [R7]
				`LBC_MIRR_HI_ADDR: next_mirrorCtl[NL-1:8] = regWdata[`LBC_HI_BITS-1:0];
				`LBC_LINK_LO_ADDR: next_linkCtl[7:0] = regWdata;
				`LBC_LINK_HI_ADDR: next_linkCtl[NL-1:8] = regWdata[`LBC_HI_BITS-1:0];
				`LBC_BEH_0_ADDR: next_behav[7:0] = regWdata;
				`LBC_BEH_1_ADDR: next_behav[15:8] = regWdata;
				`LBC_BEH_2_ADDR: next_behav[23:16] = regWdata;
				`LBC_P1_DUTY_ADDR: next_dutyP1 = regWdata; // [R5]
				`LBC_P2_DUTY_ADDR: next_dutyP2 = regWdata;
				`LBC_BR_DUTY_ADDR: next_dutyBr = regWdata;
				`LBC_DIR_DUTY_ADDR: next_dutyDir = regWdata;
				default: ; // Writes elsewhere are ignored
			endcase
		end
		// Status reads also clear the flags they return
		if (regRead) begin
			// Read data appears one cycle after the strobe; upper bits of narrow registers read zero
			case (regAddr)
				`LBC_CFG2_ADDR: next_regRdata = cfg2;
				`LBC_DONE_LO_ADDR: begin
					next_regRdata = doneStatus[7:0]; // [R4]
					clrDone[7:0] = 8'hff;
				end
				`LBC_DONE_HI_ADDR: begin
					hiPad[`LBC_HI_BITS-1:0] = doneStatus[NL-1:8];
					next_regRdata = hiPad;
					clrDone[NL-1:8] = 3'h7;
				end
				`LBC_DIR_ADDR: next_regRdata = dirCtl;
				`LBC_TYPE_ADDR: next_regRdata = typeCtl;
				`LBC_GPIN_ADDR: next_regRdata = gpioIn;
				`LBC_OUT_LO_ADDR: next_regRdata = outCtl[7:0];
				`LBC_OUT_HI_ADDR: next_regRdata = {5'h00, outCtl[NL-1:8]};
				`LBC_TRANS_LO_ADDR: next_regRdata = transCtl[7:0];
				`LBC_TRANS_HI_ADDR: next_regRdata = {5'h00, transCtl[NL-1:8]};
				`LBC_MIRR_LO_ADDR: next_regRdata = mirrorCtl[7:0];
				`LBC_MIRR_HI_ADDR: next_regRdata = {5'h00, mirrorCtl[NL-1:8]};
				`LBC_LINK_LO_ADDR: next_regRdata = linkCtl[7:0];
				`LBC_LINK_HI_ADDR: next_regRdata = {5'h00, linkCtl[NL-1:8]};
				`LBC_BEH_0_ADDR: next_regRdata = behav[7:0];
				`LBC_BEH_1_ADDR: next_regRdata = behav[15:8];
				`LBC_BEH_2_ADDR: next_regRdata = behav[23:16];
				`LBC_P1_DUTY_ADDR: next_regRdata = dutyP1;
				`LBC_P2_DUTY_ADDR: next_regRdata = dutyP2;
				`LBC_BR_DUTY_ADDR: next_regRdata = dutyBr;
				`LBC_DIR_DUTY_ADDR: next_regRdata = dutyDir;
				default: next_regRdata = 8'h00; // Unmapped reads return zero
			endcase
		end
		// Read clears, but a completion in the same cycle wins [R4]
		next_doneStatus = (doneStatus & ~clrDone) | chDone;
		// Using the next flags lets the alert rise with the flag itself
		// Interrupt follows any flag when enabled in configuration 2 [R4] [R8]
		next_ledDoneAlert = cfg2[`LBC_CFG2_DONE_INT] & (|next_doneStatus);
		// Pins set as outputs read back zero, so the register shows inputs only
		// GPIO inputs taken as synchronous levels
		next_gpioIn = lampIn & dirCtl;
	end

	// Synchronous reset; duty codes come up at their defaults, the rest cleared
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			doneStatus <= '0;
			transCtl <= '0;
			mirrorCtl <= '0;
			outCtl <= '0;
			linkCtl <= '0;
			behav <= '0;
			cfg2 <= `LBC_ZERO_RST;
			dutyP1 <= `LBC_DUTY_RST;
			dutyP2 <= `LBC_DUTY_RST;
			dutyBr <= `LBC_DUTY_RST;
			dutyDir <= `LBC_DUTY_RST;
			dirCtl <= `LBC_ZERO_RST;
			typeCtl <= `LBC_ZERO_RST;
			gpioIn <= `LBC_ZERO_RST;
			regRdata <= `LBC_ZERO_RST;
			ledDoneAlert <= 1'b0;
		end else begin
			doneStatus <= next_doneStatus;
			transCtl <= next_transCtl;
			mirrorCtl <= next_mirrorCtl;
			outCtl <= next_outCtl;
			linkCtl <= next_linkCtl;
			behav <= next_behav;
			cfg2 <= next_cfg2;
			dutyP1 <= next_dutyP1;
			dutyP2 <= next_dutyP2;
			dutyBr <= next_dutyBr;
			dutyDir <= next_dutyDir;
			dirCtl <= next_dirCtl;
			typeCtl <= next_typeCtl;
			gpioIn <= next_gpioIn;
			regRdata <= next_regRdata;
			ledDoneAlert <= next_ledDoneAlert;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin drivers: open-drain sink unless a GPIO is reconfigured
	// Lamps above the first eight have no GPIO role and stay sink-only
	always_comb begin
		for (int i = 0; i < NL; i++) begin
			// Open drain pulls low while the LED is lit [R9]
			next_lampOut[i] = 1'b0;
			next_lampOe[i] = chDrive[i];
			// Only reconfigurable pins look at the GPIO settings
			if (i < NG) begin
				if (dirCtl[i]) begin
					next_lampOe[i] = 1'b0; // Input: pin released [R9]
				end else if (typeCtl[i]) begin
					next_lampOut[i] = chDrive[i]; // Push-pull drives both ways [R9]
					next_lampOe[i] = 1'b1;
				end
			end
		end
	end

	// Pin registers, so decode glitches never reach the pins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lampOut <= '0;
			lampOe <= '0;
		end else begin
			lampOut <= next_lampOut;
			lampOe <= next_lampOe;
		end
	end
endmodule // lbc_led_ctrl

// >>> lbc_lamp_model.sv
`timescale 1ns/1ps
// Lamps, pull-ups and an outside driver on the channel pins
module lbc_lamp_model (
	input wire logic [10:0] lampOut,
	input wire logic [10:0] lampOe,
	input wire logic [7:0] extLevel,
	input wire logic [7:0] extDrive,
	output logic [7:0] lampIn,
	output logic [10:0] lit
);
	logic [10:0] pin; // Resolved pin level
	logic [10:0] drv; // Outside driver enables, none above lamp 7
	assign drv = {3'b000, extDrive};
	// Device drive wins, then the outside driver, else the pull-up holds the pin high
	always_comb begin
		for (int i = 0; i < 11; i++) begin
			pin[i] = lampOe[i] ? lampOut[i] : (drv[i] ? extLevel[i] : 1'b1);
		end
	end
	// A lamp sinks current into a low pin
	assign lit = ~pin;
	assign lampIn = pin[7:0];
endmodule // lbc_lamp_model

// >>> lbc_ctrl_asserts.sv
`timescale 1ns/1ps
`include "lbc_consts.svh"
// Port-level checks on the LED controller
module lbc_ctrl_checker #(
	parameter int PWM_CYCLES = `LBC_PWM_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic [`LBC_NUM_LED-1:0] sensorTouched,
	input wire logic [`LBC_NUM_GPIO-1:0] lampIn,
	input wire logic [`LBC_NUM_LED-1:0] lampOut,
	input wire logic [`LBC_NUM_LED-1:0] lampOe,
	input wire logic ledDoneAlert
);
	logic doneEn, next_doneEn; // Shadow of the completion interrupt enable
	logic [7:0] dirIn, next_dirIn; // Shadow of the direction register
	logic [7:0] pushPull, next_pushPull; // Shadow of the output type register
	////////////////////////////////////////////////////////////
	// Follow host writes; shadows avoid peeking into the design
	always_comb begin
		next_doneEn = doneEn;
		next_dirIn = dirIn;
		next_pushPull = pushPull;
		if (regWrite && regAddr == 8'h40) next_doneEn = regWdata[0];
		if (regWrite && regAddr == 8'h70) next_dirIn = regWdata;
		if (regWrite && regAddr == 8'h71) next_pushPull = regWdata;
	end
	// Shadows clear with the design's reset
	always_ff @(posedge core_clk) begin
		doneEn <= rst_n ? next_doneEn : 1'b0;
		dirIn <= rst_n ? next_dirIn : 8'h00;
		pushPull <= rst_n ? next_pushPull : 8'h00;
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence hiRead;
		regRead && regAddr inside {8'h61, 8'h75, 8'h78, 8'h7a, 8'h7c};
	endsequence
	sequence voidRead;
		regRead && regAddr == 8'h00;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
		regRdata == 8'h00 && lampOe == '0 && lampOut == '0 && !ledDoneAlert) else $error("outputs not quiet in reset");
	a_rdata_hold: assert property (!regRead |=> $stable(regRdata)) else $error("read data moved without a read");
	a_unmapped_zero: assert property (voidRead |=> regRdata == 8'h00) else $error("unmapped read not zero");
	a_hi_upper: assert property (hiRead |=> regRdata[7:3] == 5'h00) else $error("upper bits of high register set");
	a_sink_only: assert property (lampOut[10:8] == 3'b000) else $error("sink-only lamp driven high");
	a_alert_masked: assert property (!doneEn [*2] |-> !ledDoneAlert) else $error("alert while disabled");
	a_gpio_input: assert property ((lampOe[7:0] & dirIn & $past(dirIn, 3)) == 8'h00)
		else $error("input pin driven");
	a_push_pull: assert property ((pushPull & ~dirIn & $past(pushPull, 3) & ~$past(dirIn, 3) & ~lampOe[7:0]) == 8'h00)
		else $error("push-pull pin not driven");
	a_open_drain: assert property ((lampOut[7:0] & ~pushPull & ~$past(pushPull, 3)) == 8'h00)
		else $error("open-drain pin driven high");
endmodule // lbc_ctrl_checker

bind lbc_led_ctrl lbc_ctrl_checker #(.PWM_CYCLES(PWM_CYCLES)) lbc_ctrl_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.sensorTouched(sensorTouched), .lampIn(lampIn), .lampOut(lampOut), .lampOe(lampOe), .ledDoneAlert(ledDoneAlert));

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int P = 200; // Short PWM period keeps the run brief
	logic core_clk, rst_n, regWrite, regRead, ledDoneAlert;
	logic [7:0] regAddr, regWdata, regRdata, lampIn, extLevel, extDrive;
	logic [10:0] sensorTouched, lampOut, lampOe, lit;
	int mismatches = 0;
	int checksDone = 0;
	lbc_led_ctrl #(.PWM_CYCLES(P)) lbc_led_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.sensorTouched(sensorTouched), .lampIn(lampIn), .lampOut(lampOut), .lampOe(lampOe), .ledDoneAlert(ledDoneAlert));
	lbc_lamp_model lbc_lamp_model_inst (.lampOut(lampOut), .lampOe(lampOe), .extLevel(extLevel),
		.extDrive(extDrive), .lampIn(lampIn), .lit(lit));
	always #50 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////
	// Verdict in one place
	task automatic summarize;
		$display("mismatches=%0d checks=%0d", mismatches, checksDone);
		if (mismatches == 0 && checksDone > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle strobes set at the falling edge, taken at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge core_clk);
		regWrite = 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge core_clk);
		regRead = 1'b0;
		check(16'(regRdata), 16'(exp));
	endtask
	task automatic waitCyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Lit cycles over one whole period; any window of that length sees one period
	task automatic onCount(input int ch, output int n);
		n = 0;
		repeat (P) begin
			@(negedge core_clk);
			n += int'(lit[ch] === 1'b1);
		end
	endtask
	// Bounded wait for the alert; running out ends the run
	task automatic waitAlert(input int lim, output int k);
		for (k = 0; k < lim && ledDoneAlert !== 1'b1; k++) @(negedge core_clk);
		if (k == lim) begin
			mismatches++;
			summarize();
		end
	endtask
	////////////////////////////////////////////////////////////
	// Reset values, access kinds, pairing and an unmapped place
	task automatic regScenario;
		logic [7:0] a [10] = '{8'h60, 8'h61, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h90, 8'h91, 8'h92, 8'h93};
		for (int i = 0; i < 10; i++) rdChk(a[i], i < 6 ? 8'h00 : 8'hf0);
		for (int i = 0; i < 10; i++) wr(a[i], 8'h5a);
		for (int i = 0; i < 10; i++) rdChk(a[i], i < 2 ? 8'h00 : (i == 3 || i == 5) ? 8'h02 : 8'h5a);
		rdChk(8'h40, 8'h00);
		wr(8'h40, 8'hfc);
		rdChk(8'h40, 8'hfc);
		rdChk(8'h00, 8'h00);
		for (int i = 2; i < 10; i++) wr(a[i], i < 6 ? 8'h00 : 8'hf0);
		wr(8'h40, 8'h00);
	endtask
	// Host touch on an unlinked lamp, every bright code, mirroring
	task automatic directScenario;
		int pct [16] = '{0, 7, 9, 11, 14, 17, 20, 23, 26, 30, 35, 40, 46, 53, 64, 100};
		int n;
		wr(8'h74, 8'h01);
		for (int c = 0; c < 16; c++) begin
			wr(8'h93, {c[3:0], 4'h0});
			waitCyc(P);
			onCount(0, n);
			check(16'(n), 16'(pct[c] * P / 100));
		end
		wr(8'h93, 8'hd0);
		wr(8'h79, 8'h01);
		waitCyc(P);
		onCount(0, n);
		check(16'(n), 16'(47 * P / 100));
		wr(8'h74, 8'h00);
		waitCyc(P);
		onCount(0, n);
		check(16'(n), 16'(P));
		wr(8'h79, 8'h00);
		wr(8'h93, 8'hf0);
		waitCyc(P);
		onCount(0, n);
		check(16'(n), 16'h0000);
		rdChk(8'h60, 8'h01);
	endtask
	// First pulse on press then on release, status and alert
	task automatic pulseScenario;
		int k;
		wr(8'h81, 8'h04);
		wr(8'h74, 8'h02);
		waitCyc(7 * P);
		rdChk(8'h60, 8'h00);
		waitCyc(3 * P);
		rdChk(8'h60, 8'h02);
		check(16'(ledDoneAlert), 16'h0000);
		rdChk(8'h60, 8'h00);
		wr(8'h74, 8'h00);
		wr(8'h40, 8'h03);
		wr(8'h74, 8'h02);
		waitCyc(10 * P);
		check(16'(ledDoneAlert), 16'h0000);
		wr(8'h74, 8'h00);
		waitAlert(10 * P, k);
		check(16'(k >= 7 * P), 16'h0001);
		rdChk(8'h60, 8'h02);
		waitCyc(1);
		check(16'(ledDoneAlert), 16'h0000);
		wr(8'h81, 8'h00);
		wr(8'h40, 8'h00);
	endtask
	// Blink and breathe on host-driven lamps, done on release
	task automatic patternScenario;
		int n;
		wr(8'h82, 8'he0);
		wr(8'h74, 8'hc0);
		onCount(6, n);
		check(16'(n), 16'h0000);
		waitCyc(8 * P);
		onCount(6, n);
		check(16'(n), 16'(P));
		onCount(7, n);
		check(16'(n >= 18 && n <= 24), 16'h0001);
		wr(8'h74, 8'h00);
		waitCyc(2);
		rdChk(8'h60, 8'hc0);
		wr(8'h82, 8'h00);
	endtask
	// Input and push-pull pin modes
	task automatic gpioScenario;
		wr(8'h70, 8'h04);
		extDrive = 8'h04;
		waitCyc(3);
		rdChk(8'h72, 8'h00);
		extLevel = 8'h04;
		waitCyc(3);
		rdChk(8'h72, 8'h04);
		wr(8'h71, 8'h08);
		wr(8'h74, 8'h0c);
		waitCyc(P);
		check(16'({lampOe[3], lampOut[3]}), 16'h0003);
		check(16'(lampOe[2]), 16'h0000);
		wr(8'h74, 8'h00);
		waitCyc(P);
		check(16'({lampOe[3], lampOut[3]}), 16'h0002);
		rdChk(8'h60, 8'h0c);
		wr(8'h70, 8'h00);
		wr(8'h71, 8'h00);
		extDrive = 8'h00;
	endtask
	// Linked lamps: one ramps in, one jumps
	task automatic linkScenario;
		int n;
		wr(8'h7b, 8'h30);
		wr(8'h77, 8'h10);
		sensorTouched = 11'h030;
		waitCyc(2 * P);
		onCount(4, n);
		check(16'(n < P / 10), 16'h0001);
		onCount(5, n);
		check(16'(n), 16'(P));
		sensorTouched = 11'h000;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		sensorTouched = 11'h000;
		extLevel = 8'h00;
		extDrive = 8'h00;
		waitCyc(2);
		rst_n = 1'b1;
		regScenario();
		directScenario();
		pulseScenario();
		patternScenario();
		gpioScenario();
		linkScenario();
		summarize();
	end
endmodule // tb_top
